// ==== logic/ecgcc_channel_config.sv ====
// Behaviour
// - Channel config register is read/write, 24 bits wide, at index 0x15.
// - A changing config write may disturb the sample stream; flagged until resync.
// - Rate field bits 23:22, reset 10; 32768 Hz gives 512, 256, 128 sps.
// - Master clock select 01 gives 500, 250 and 125 sps.
// - Selects 10 and 11 allow only rate code 10: 200 or 199.8 sps.
// - Gain field bits 17:16, reset 00; codes give 20, 40, 80, 160 V/V.
// - High-pass bit 14, reset 1; 0 bypasses, 1 gives 0.50 Hz cutoff.
// - Low-pass bits 13:12, reset 01; 00 decimation only, else about 40/100/150 Hz.
// - Low-pass 10 only at 512/256/500/250 sps; 11 only at 512/500 sps.
// - Unsupported low-pass code filters as 01; stored as written, reads back effective.
// - At 128 sps non-bypass cutoff is 28.35 Hz; at 125 sps 27.68 Hz.
// - Unsupported combinations take the rate's default cutoff, e.g. 40.96 or 40.00 Hz.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module ecgcc_channel_config (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  wb_cyc_i,
   input  wire logic                                  wb_stb_i,
   input  wire logic                                  wb_we_i,
   input  wire logic [ecgcc_pkg::ADDR_W-1:0]          wb_adr_i,
   input  wire logic [3:0]                            wb_sel_i,
   input  wire logic [31:0]                           wb_dat_i,
   output logic      [31:0]                           wb_dat_o,
   output logic                                       wb_ack_o,
   input  wire logic [1:0]                            masterClockSelect,
   output ecgcc_pkg::ecgcc_eff_t                      effConfig,
   output logic                                       configDisturbed,
   output logic                                       resyncCommand
);

   ecgcc_pkg::ecgcc_state_t stQ;
   ecgcc_pkg::ecgcc_state_t stD;

   logic        req;
   logic        wrReq;
   logic        rdReq;
   logic [5:0]  idx;
   logic        cfgWr;
   logic        rsWr;
   logic [23:0] wrMask;
   logic [23:0] cfgNew;
   logic [23:0] cfgView;
   logic [1:0]  rateNow;
   logic [1:0]  gainNow;
   logic [1:0]  lpfStored;
   logic [1:0]  lpfNow;
   logic        validNow;
   logic [13:0] dspsNow;
   logic [13:0] cutNow;

   // Request decode; ack holds one cycle so a held strobe is taken once
   always_comb begin
      req   = wb_cyc_i & wb_stb_i & ~stQ.ack;
      wrReq = req & wb_we_i;
      rdReq = req & ~wb_we_i;
      idx   = wb_adr_i[ecgcc_pkg::ADDR_W-1:2];
      cfgWr = wrReq && (idx == ecgcc_pkg::CFG_IDX);
      rsWr  = wrReq && (idx == ecgcc_pkg::CTRL_IDX) &&
              wb_sel_i[0] && wb_dat_i[ecgcc_pkg::RESYNC_BIT];
   end

   // Field taps of the stored configuration
   always_comb begin
      rateNow   = stQ.cfg[ecgcc_pkg::RATE_HI:ecgcc_pkg::RATE_LO];
      gainNow   = stQ.cfg[ecgcc_pkg::GAIN_HI:ecgcc_pkg::GAIN_LO];
      lpfStored = stQ.cfg[ecgcc_pkg::LPF_HI:ecgcc_pkg::LPF_LO];
   end

   ecgcc_map u_map (
      .masterClockSelect (masterClockSelect),
      .rateCode          (rateNow),
      .lowpassSelect     (lpfStored),
      .lowpassEffective  (lpfNow),
      .rateValid         (validNow),
      .rateDsps          (dspsNow),
      .cutoffCHz         (cutNow)
   );

   // Byte lanes 0..2 carry the 24-bit field; only assigned bits take writes
   always_comb begin
      wrMask = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & ecgcc_pkg::CFG_WMASK;
      cfgNew = (stQ.cfg & ~wrMask) | (wb_dat_i[23:0] & wrMask);
      cfgView = stQ.cfg;
      // Readback shows the filter in effect, storage keeps the written code
      cfgView[ecgcc_pkg::LPF_HI:ecgcc_pkg::LPF_LO] = lpfNow;
   end

   always_comb begin
      stD        = stQ;
      stD.ack    = req;
      stD.resync = 1'h0;
      if (cfgWr) begin
         stD.cfg = cfgNew;
      end
      // Resync clears the disturbance flag; a changing write in the same cycle wins
      if (rsWr) begin
         stD.resync  = 1'h1;
         stD.changed = 1'h0;
      end
      if (cfgWr && cfgNew != stQ.cfg) begin
         stD.changed = 1'h1;
      end
      stD.rdat = 32'h0000_0000;
      if (rdReq) begin
         unique case (idx)
            ecgcc_pkg::CFG_IDX:  stD.rdat = {8'h00, cfgView};
            ecgcc_pkg::STAT_IDX: stD.rdat = {26'h0, masterClockSelect, lpfNow, validNow, stQ.changed};
            default:             stD.rdat = 32'h0000_0000;
         endcase
      end
      // Effective settings follow the stored fields one edge later
      stD.eff.rate      = rateNow;
      stD.eff.gain      = gainNow;
      stD.eff.gainVv    = ecgcc_pkg::GAIN_VV[gainNow];
      stD.eff.hpf       = stQ.cfg[ecgcc_pkg::HPF_BIT];
      stD.eff.lpf       = lpfNow;
      stD.eff.rateValid = validNow;
      stD.eff.rateDsps  = dspsNow;
      stD.eff.cutoffCHz = cutNow;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stQ     <= '0;
         stQ.cfg <= ecgcc_pkg::CFG_RST;
      end else begin
         stQ <= stD;
      end
   end

   always_comb begin
      wb_dat_o        = stQ.rdat;
      wb_ack_o        = stQ.ack;
      effConfig       = stQ.eff;
      configDisturbed = stQ.changed;
      resyncCommand   = stQ.resync;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Sampled rstn in antecedents keeps the release edge away from the registered effect outputs

   // Every taken request is answered exactly one edge later, then released
   wb_ack_a: assert property (
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after the request");

   cfg_write_a: assert property (
      (cfgWr && (&wb_sel_i[2:0])) |=>
         stQ.cfg == ($past(wb_dat_i[23:0]) & ecgcc_pkg::CFG_WMASK))
      else $error("config write not stored as masked data");

   cfg_read_a: assert property (
      (rdReq && idx == ecgcc_pkg::CFG_IDX) |=>
         wb_dat_o[13:12] == $past(lpfNow) &&
         wb_dat_o[31:24] == 8'h00 &&
         (wb_dat_o[23:0] & ~ecgcc_pkg::CFG_WMASK) == 24'h000000 &&
         wb_dat_o[23:22] == $past(rateNow))
      else $error("config readback wrong");

   chg_set_a: assert property (
      (cfgWr && cfgNew != stQ.cfg) |=> configDisturbed)
      else $error("changing write did not flag disturbance");

   chg_hold_a: assert property (
      (configDisturbed && !rsWr) |=> configDisturbed)
      else $error("disturbance flag dropped without resync");

   resync_a: assert property (
      (rsWr && !cfgWr) |=> resyncCommand && !configDisturbed ##1 !resyncCommand)
      else $error("resync pulse or clear wrong");

   rate_fast_a: assert property (
      (!masterClockSelect[1] && rateNow == 2'h0) |=>
         effConfig.rateDsps == ($past(masterClockSelect[0]) ? 14'h1388 : 14'h1400))
      else $error("top rate wrong");

   rate_low_a: assert property (
      (rstn && !masterClockSelect[1] && rateNow == 2'h2) |=>
         effConfig.rateDsps == ($past(masterClockSelect[0]) ? 14'h04E2 : 14'h0500))
      else $error("low rate wrong");

   rate_slow_a: assert property (
      (rstn && masterClockSelect[1]) |=>
         ($past(rateNow) == 2'h2) ?
            (effConfig.rateValid &&
             effConfig.rateDsps == ($past(masterClockSelect[0]) ? 14'h07CE : 14'h07D0)) :
            !effConfig.rateValid)
      else $error("rate for slow master clock wrong");

   gain_a: assert property (
      rstn |=> effConfig.gainVv == (8'h14 << $past(gainNow)))
      else $error("gain value wrong");

   hpf_a: assert property (
      rstn |=> effConfig.hpf == $past(stQ.cfg[ecgcc_pkg::HPF_BIT]))
      else $error("high-pass select not applied");

   bypass_a: assert property (
      (lpfStored == 2'h0) |=> effConfig.lpf == 2'h0 && effConfig.cutoffCHz == 14'h0000)
      else $error("bypass not applied");

   lpf_remap_a: assert property (
      ((lpfStored == 2'h3 && rateNow != 2'h0) ||
       (lpfStored == 2'h2 && rateNow == 2'h2) ||
       (lpfStored[1] && masterClockSelect[1])) |=> effConfig.lpf == 2'h1)
      else $error("unsupported low-pass not remapped");

   low_cut_a: assert property (
      (rstn && !masterClockSelect[1] && rateNow == 2'h2 && lpfStored != 2'h0) |=>
         effConfig.cutoffCHz == ($past(masterClockSelect[0]) ? 14'h0AD0 : 14'h0B13))
      else $error("low rate cutoff wrong");

   def_cut_a: assert property (
      (!masterClockSelect[1] && rateNow == 2'h1 && lpfStored == 2'h3) |=>
         effConfig.cutoffCHz == ($past(masterClockSelect[0]) ? 14'h0FA0 : 14'h1000))
      else $error("default cutoff not used");

   // Handshake, idle read data, status read and unmapped accesses
   ack_idle_a: assert property (
      !req |=> !wb_ack_o)
      else $error("ack without a taken request");

   ack_once_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   rdat_idle_a: assert property (
      !rdReq |=> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside a read ack");

   unmapped_read_a: assert property (
      (rdReq && idx != ecgcc_pkg::CFG_IDX && idx != ecgcc_pkg::STAT_IDX) |=>
         wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   status_read_a: assert property (
      (rdReq && idx == ecgcc_pkg::STAT_IDX) |=>
         wb_dat_o[0] == $past(stQ.changed) &&
         wb_dat_o[1] == $past(validNow) &&
         wb_dat_o[3:2] == $past(lpfNow) &&
         wb_dat_o[5:4] == $past(masterClockSelect) &&
         wb_dat_o[31:6] == 26'h0000000)
      else $error("status readback wrong");

   unmapped_write_a: assert property (
      (wrReq && idx != ecgcc_pkg::CFG_IDX && idx != ecgcc_pkg::CTRL_IDX) |=>
         stQ.cfg == $past(stQ.cfg) && !resyncCommand)
      else $error("unmapped write had an effect");

   // Storage: only written lanes and assigned bits change
   cfg_hold_a: assert property (
      !cfgWr |=> stQ.cfg == $past(stQ.cfg))
      else $error("config changed without a write");

   lane2_keep_a: assert property (
      (cfgWr && !wb_sel_i[2]) |=> stQ.cfg[23:16] == $past(stQ.cfg[23:16]))
      else $error("unselected upper lane written");

   lane1_keep_a: assert property (
      (cfgWr && !wb_sel_i[1]) |=> stQ.cfg[15:8] == $past(stQ.cfg[15:8]))
      else $error("unselected middle lane written");

   unassigned_a: assert property (
      (stQ.cfg & ~ecgcc_pkg::CFG_WMASK) == 24'h000000)
      else $error("unassigned config bit set");

   lpf_store_a: assert property (
      (cfgWr && wb_sel_i[1]) |=>
         stQ.cfg[ecgcc_pkg::LPF_HI:ecgcc_pkg::LPF_LO] == $past(wb_dat_i[13:12]))
      else $error("written low-pass code not stored as written");

   // Disturbance flag and resync pulse
   chg_same_a: assert property (
      (cfgWr && cfgNew == stQ.cfg && !configDisturbed) |=> !configDisturbed)
      else $error("unchanged write flagged disturbance");

   chg_quiet_a: assert property (
      (!configDisturbed && !cfgWr) |=> !configDisturbed)
      else $error("disturbance flag set without a write");

   resync_idle_a: assert property (
      !rsWr |=> !resyncCommand)
      else $error("resync pulse without a command");

   // Effective settings against the fixed tables
   eff_fields_a: assert property (
      rstn |=> effConfig.rate == $past(rateNow) && effConfig.gain == $past(gainNow))
      else $error("effective rate or gain not taken from storage");

   gain_top_a: assert property (
      (rstn && gainNow == 2'h3) |=> effConfig.gainVv == 8'hA0)
      else $error("top gain wrong");

   hpf_bypass_a: assert property (
      (rstn && !stQ.cfg[ecgcc_pkg::HPF_BIT]) |=> !effConfig.hpf)
      else $error("high-pass bypass not applied");

   lpf_pass_a: assert property (
      (rstn && !lpfStored[1]) |=> effConfig.lpf == $past(lpfStored))
      else $error("supported low-pass code changed");

   rate_valid_a: assert property (
      (rstn && !masterClockSelect[1] && !rateNow[1]) |=> effConfig.rateValid)
      else $error("legal high rate marked invalid");

   rate_mid_a: assert property (
      (rstn && !masterClockSelect[1] && rateNow == 2'h1) |=>
         effConfig.rateDsps == ($past(masterClockSelect[0]) ? 14'h09C4 : 14'h0A00))
      else $error("middle rate wrong");

   cut_def_a: assert property (
      (rstn && !masterClockSelect[1] && !rateNow[1] && lpfStored == 2'h1) |=>
         effConfig.cutoffCHz == ($past(masterClockSelect[0]) ? 14'h0FA0 : 14'h1000))
      else $error("default cutoff at high rate wrong");

   cut_100_a: assert property (
      (rstn && !masterClockSelect[1] && !rateNow[1] && lpfStored == 2'h2) |=>
         effConfig.lpf == 2'h2 &&
         effConfig.cutoffCHz == ($past(masterClockSelect[0]) ? 14'h2710 : 14'h2800))
      else $error("100 Hz class cutoff wrong");

   cut_150_a: assert property (
      (rstn && !masterClockSelect[1] && rateNow == 2'h0 && lpfStored == 2'h3) |=>
         effConfig.lpf == 2'h3 &&
         effConfig.cutoffCHz == ($past(masterClockSelect[0]) ? 14'h3A98 : 14'h3C00))
      else $error("150 Hz class cutoff wrong");

   slow_cut_a: assert property (
      (rstn && masterClockSelect[1] && rateNow == 2'h2 && lpfStored != 2'h0) |=>
         effConfig.lpf == 2'h1 &&
         effConfig.cutoffCHz == ($past(masterClockSelect[0]) ? 14'h0F9C : 14'h0FA0))
      else $error("slow master clock cutoff wrong");

endmodule : ecgcc_channel_config

`default_nettype wire

// ==== shared/ecgcc_pkg.sv ====
package ecgcc_pkg;

   // Wishbone word index decode (byte address = 4 x index)
   localparam int unsigned ADDR_W     = 8;
   localparam logic [5:0]  CFG_IDX    = 6'h15;
   localparam logic [5:0]  CTRL_IDX   = 6'h30;
   localparam logic [5:0]  STAT_IDX   = 6'h31;

   // Channel configuration layout
   localparam int unsigned RATE_HI    = 23;
   localparam int unsigned RATE_LO    = 22;
   localparam int unsigned GAIN_HI    = 17;
   localparam int unsigned GAIN_LO    = 16;
   localparam int unsigned HPF_BIT    = 14;
   localparam int unsigned LPF_HI     = 13;
   localparam int unsigned LPF_LO     = 12;
   localparam logic [23:0] CFG_RST    = 24'h805000;
   localparam logic [23:0] CFG_WMASK  = 24'hC37000;

   // Control and status layout
   localparam int unsigned RESYNC_BIT = 0;
   localparam int unsigned CHG_BIT    = 0;
   localparam int unsigned VALID_BIT  = 1;

   // Rate and low-pass codes
   localparam logic [1:0]  RATE_TOP   = 2'h0;
   localparam logic [1:0]  RATE_LOW   = 2'h2;
   localparam logic [1:0]  LPF_BYPASS = 2'h0;
   localparam logic [1:0]  LPF_DEF    = 2'h1;
   localparam logic [1:0]  LPF_100    = 2'h2;
   localparam logic [1:0]  LPF_150    = 2'h3;

   // Sample rate in 0.1 sps, indexed [master clock select][rate code]; zero marks reserved
   localparam logic [13:0] RATE_DSPS [4][4] = '{
      '{14'h1400, 14'h0A00, 14'h0500, 14'h0000},
      '{14'h1388, 14'h09C4, 14'h04E2, 14'h0000},
      '{14'h0000, 14'h0000, 14'h07D0, 14'h0000},
      '{14'h0000, 14'h0000, 14'h07CE, 14'h0000}};

   // Default low-pass cutoff in 0.01 Hz, same indexing
   localparam logic [13:0] CUT_DEF [4][4] = '{
      '{14'h1000, 14'h1000, 14'h0B13, 14'h0000},
      '{14'h0FA0, 14'h0FA0, 14'h0AD0, 14'h0000},
      '{14'h0000, 14'h0000, 14'h0FA0, 14'h0000},
      '{14'h0000, 14'h0000, 14'h0F9C, 14'h0000}};

   // Wider cutoffs exist only for master clock selects 00 and 01
   localparam logic [13:0] CUT_100 [2] = '{14'h2800, 14'h2710};
   localparam logic [13:0] CUT_150 [2] = '{14'h3C00, 14'h3A98};

   // Channel gain in V/V per gain code
   localparam logic [7:0]  GAIN_VV [4] = '{8'h14, 8'h28, 8'h50, 8'hA0};

   typedef struct packed {
      logic [1:0]  rate;
      logic [1:0]  gain;
      logic        hpf;
      logic [1:0]  lpf;
      logic        rateValid;
      logic [13:0] rateDsps;
      logic [13:0] cutoffCHz;
      logic [7:0]  gainVv;
   } ecgcc_eff_t;

   typedef struct packed {
      logic [23:0] cfg;
      logic        ack;
      logic [31:0] rdat;
      logic        changed;
      logic        resync;
      ecgcc_eff_t  eff;
   } ecgcc_state_t;

endpackage : ecgcc_pkg

// ==== logic/ecgcc_map.sv ====
`timescale 1ns/1ps
`default_nettype none

module ecgcc_map (
   input  wire logic [1:0]  masterClockSelect,
   input  wire logic [1:0]  rateCode,
   input  wire logic [1:0]  lowpassSelect,
   output logic      [1:0]  lowpassEffective,
   output logic             rateValid,
   output logic      [13:0] rateDsps,
   output logic      [13:0] cutoffCHz
);

   logic fastClk;

   always_comb begin
      fastClk          = ~masterClockSelect[1];
      rateDsps         = ecgcc_pkg::RATE_DSPS[masterClockSelect][rateCode];
      rateValid        = (rateDsps != 14'h0000);
      lowpassEffective = lowpassSelect;
      // Unsupported wide filters fall back to the default filter
      if (lowpassSelect == ecgcc_pkg::LPF_100 &&
          !(fastClk && rateValid && rateCode != ecgcc_pkg::RATE_LOW)) begin
         lowpassEffective = ecgcc_pkg::LPF_DEF;
      end
      if (lowpassSelect == ecgcc_pkg::LPF_150 &&
          !(fastClk && rateCode == ecgcc_pkg::RATE_TOP)) begin
         lowpassEffective = ecgcc_pkg::LPF_DEF;
      end
      unique case (lowpassEffective)
         ecgcc_pkg::LPF_BYPASS: cutoffCHz = 14'h0000;
         ecgcc_pkg::LPF_DEF:    cutoffCHz = ecgcc_pkg::CUT_DEF[masterClockSelect][rateCode];
         ecgcc_pkg::LPF_100:    cutoffCHz = ecgcc_pkg::CUT_100[masterClockSelect[0]];
         ecgcc_pkg::LPF_150:    cutoffCHz = ecgcc_pkg::CUT_150[masterClockSelect[0]];
      endcase
   end

endmodule : ecgcc_map

`default_nettype wire

// ==== tb/ecgcc_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam logic [13:0] EXP_RATE [4][4] = '{'{14'h1400, 14'h0A00, 14'h0500, 14'h0000},
      '{14'h1388, 14'h09C4, 14'h04E2, 14'h0000}, '{14'h0000, 14'h0000, 14'h07D0, 14'h0000},
      '{14'h0000, 14'h0000, 14'h07CE, 14'h0000}};
   localparam logic [13:0] EXP_CUT [4][4] = '{'{14'h1000, 14'h1000, 14'h0B13, 14'h0000},
      '{14'h0FA0, 14'h0FA0, 14'h0AD0, 14'h0000}, '{14'h0000, 14'h0000, 14'h0FA0, 14'h0000},
      '{14'h0000, 14'h0000, 14'h0F9C, 14'h0000}};
   logic                  clk = 1'b0;
   logic                  rstn = 1'b0;
   logic                  cyc = 1'b0;
   logic                  stb = 1'b0;
   logic                  we = 1'b0;
   logic [7:0]            adr = 8'h00;
   logic [3:0]            sel = 4'h0;
   logic [31:0]           datI = 32'h00000000;
   logic [31:0]           datO;
   logic                  ack;
   logic [1:0]            msel = 2'h0;
   ecgcc_pkg::ecgcc_eff_t effConfig;
   logic                  disturbed;
   logic                  resync;
   logic [31:0]           rd;
   logic                  rsAtAck;
   int                    n_mismatch = 0;
   int                    checks_done = 0;

   ecgcc_channel_config i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
      .masterClockSelect(msel), .effConfig(effConfig), .configDisturbed(disturbed), .resyncCommand(resync));

   always #20 clk = ~clk;

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   // Classic cycle: hold everything until ack is seen at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      datI <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = datO;
      rsAtAck = resync;
      if (n >= 20) cmp(1'b0, 1'b1, "ack timeout");
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : bus

   function automatic ecgcc_pkg::ecgcc_eff_t expEff(input logic [1:0] m, r, g, input logic h, input logic [1:0] l);
      ecgcc_pkg::ecgcc_eff_t e;
      logic                  hi;
      hi = (m < 2'h2);
      e.rate = r;
      e.gain = g;
      e.hpf = h;
      e.lpf = ((l == 2'h2 && !(hi && r < 2'h2)) || (l == 2'h3 && !(hi && r == 2'h0))) ? 2'h1 : l;
      e.rateDsps = EXP_RATE[m][r];
      e.rateValid = (e.rateDsps != 14'h0000);
      e.cutoffCHz = (!e.rateValid || e.lpf == 2'h0) ? 14'h0000 : (e.lpf == 2'h1) ? EXP_CUT[m][r] :
         (e.lpf == 2'h2) ? (m[0] ? 14'h2710 : 14'h2800) : (m[0] ? 14'h3A98 : 14'h3C00);
      e.gainVv = 8'h14 << g;
      return e;
   endfunction : expEff

   function automatic logic [31:0] cfgWord(input logic [1:0] r, g, input logic h, input logic [1:0] l);
      return {8'h00, r, 4'h0, g, 1'b0, h, l, 12'h000};
   endfunction : cfgWord

   task automatic test_reset;
      repeat (6) @(posedge clk);
      cmp(effConfig, 64'h0, "eff in reset");
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      cmp(effConfig, expEff(2'h0, 2'h2, 2'h0, 1'b1, 2'h1), "eff after reset");
      bus(1'b0, 8'h54, 4'hF, 32'h0);
      cmp(rd, 32'h00805000, "cfg reset");
      cmp(disturbed, 1'b0, "disturbed after reset");
   endtask : test_reset

   // Every clock select, valid rate, gain and low-pass code
   task automatic test_map;
      for (int m = 0; m < 4; m++) begin
         msel <= m[1:0];
         for (int r = 0; r < 4; r++) begin
            if (EXP_RATE[m][r] == 14'h0000) continue;
            for (int l = 0; l < 4; l++) begin
               bus(1'b1, 8'h54, 4'h7, cfgWord(r[1:0], l[1:0], r[0], l[1:0]));
               @(posedge clk);
               cmp(effConfig, expEff(m[1:0], r[1:0], l[1:0], r[0], l[1:0]), "eff map");
               bus(1'b0, 8'h54, 4'hF, 32'h0);
               cmp(rd, cfgWord(r[1:0], l[1:0], r[0], expEff(m[1:0], r[1:0], 2'h0, 1'b0, l[1:0]).lpf), "readback");
            end
         end
      end
   endtask : test_map

   // Stored code survives while only the rate lane changes
   task automatic test_stored_lpf;
      msel <= 2'h0;
      bus(1'b1, 8'h54, 4'h7, cfgWord(2'h1, 2'h0, 1'b1, 2'h3));
      bus(1'b0, 8'h54, 4'hF, 32'h0);
      cmp(rd, cfgWord(2'h1, 2'h0, 1'b1, 2'h1), "remapped read");
      bus(1'b1, 8'h54, 4'h4, 32'h00000000);
      @(posedge clk);
      cmp(effConfig, expEff(2'h0, 2'h0, 2'h0, 1'b1, 2'h3), "stored lpf");
      bus(1'b0, 8'h54, 4'hF, 32'h0);
      cmp(rd, cfgWord(2'h0, 2'h0, 1'b1, 2'h3), "stored read");
      bus(1'b1, 8'h54, 4'h3, 32'h00FF0000);
      bus(1'b0, 8'h54, 4'hF, 32'h0);
      cmp(rd, 32'h00000000, "upper lane kept");
   endtask : test_stored_lpf

   task automatic test_unassigned;
      bus(1'b1, 8'h54, 4'hF, 32'hFF3FFFFF);
      bus(1'b0, 8'h54, 4'hF, 32'h0);
      cmp(rd, 32'h00037000, "unassigned bits");
      bus(1'b1, 8'h80, 4'hF, 32'h00000000);
      bus(1'b0, 8'h80, 4'hF, 32'h0);
      cmp(rd, 32'h0, "unmapped read");
      bus(1'b0, 8'h54, 4'hF, 32'h0);
      cmp(rd, 32'h00037000, "cfg after unmapped write");
   endtask : test_unassigned

   task automatic test_resync;
      bus(1'b1, 8'hC0, 4'h1, 32'h00000001);
      cmp(rsAtAck, 1'b1, "resync pulse");
      cmp(disturbed, 1'b0, "cleared by resync");
      cmp(resync, 1'b0, "resync one cycle");
      bus(1'b1, 8'h54, 4'h7, 32'h00037000);
      cmp(disturbed, 1'b0, "same value write");
      bus(1'b1, 8'h54, 4'h7, cfgWord(2'h2, 2'h0, 1'b1, 2'h1));
      cmp(disturbed, 1'b1, "changing write");
      bus(1'b1, 8'hC0, 4'h1, 32'h00000000);
      cmp(rsAtAck, 1'b0, "no resync on zero");
      bus(1'b0, 8'hC4, 4'hF, 32'h0);
      cmp(rd, {26'h0, 2'h0, 2'h1, 1'b1, 1'b1}, "status");
      bus(1'b1, 8'hC0, 4'h1, 32'h00000001);
      cmp(disturbed, 1'b0, "cleared again");
   endtask : test_resync

   initial begin
      #(40 * 5000);
      cmp(1'b0, 1'b1, "watchdog");
      print_verdict();
   end

   initial begin
      test_reset();
      test_map();
      test_stored_lpf();
      test_unassigned();
      test_resync();
      print_verdict();
   end
endmodule : testbench

`default_nettype wire
